//--- rtl/hpc_regs.svh
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH

// ----------------------------------------------------------------------
// Register map (word addresses on the plain port)
// ----------------------------------------------------------------------
`define HPC_ADDR_CTRL      4'h0
`define HPC_ADDR_PERIOD    4'h1
`define HPC_ADDR_EV1       4'h2
`define HPC_ADDR_EV2       4'h3
`define HPC_ADDR_EV3       4'h4
`define HPC_ADDR_EV4       4'h5
`define HPC_ADDR_SAMPLE    4'h6
`define HPC_ADDR_PHASE     4'h7
`define HPC_ADDR_SYNCTH    4'h8
`define HPC_ADDR_ADJA      4'h9
`define HPC_ADDR_ADJB      4'hA
`define HPC_ADDR_STATUS    4'hB

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define HPC_CTRL_EN        0
`define HPC_CTRL_MODE_LO   1
`define HPC_CTRL_MODE_HI   2
`define HPC_CTRL_LOOP      3
`define HPC_CTRL_POLA      4
`define HPC_CTRL_POLB      5
`define HPC_CTRL_RES_LO    6
`define HPC_CTRL_RES_HI    7
`define HPC_CTRL_SUBDIS    8
`define HPC_CTRL_OVS_LO    9
`define HPC_CTRL_OVS_HI    10
`define HPC_CTRL_SLAVE     11

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define HPC_CNT_W          14
`define HPC_EV_W           18
`define HPC_PHASE_BITS     4
`define HPC_ADJ_W          16
`define HPC_CTRL_RST       12'h000
`define HPC_PERIOD_RST     14'h00FF
`define HPC_QUARTER_DIV    2'h3

`endif

//--- rtl/hpc_pkg.sv
package hpc_pkg;

    // Operating modes of the channel
    typedef enum logic [1:0] {
        HPC_MODE_NORMAL   = 2'b00,
        HPC_MODE_PHASE    = 2'b01,
        HPC_MODE_RESONANT = 2'b10,
        HPC_MODE_MULTI    = 2'b11
    } hpc_mode_t;

    // Sub-clock resolution settings
    typedef enum logic [1:0] {
        HPC_RES_16 = 2'b00,
        HPC_RES_8  = 2'b01,
        HPC_RES_4  = 2'b10,
        HPC_RES_2  = 2'b11
    } hpc_res_t;

endpackage : hpc_pkg

//--- rtl/hpc_edge_cmp.sv
`timescale 1ns/1ps
`include "hpc_regs.svh"

// ----------------------------------------------------------------------
// One edge comparator: coarse match plus sub-clock phase select
// ----------------------------------------------------------------------
module hpc_edge_cmp (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    // Comparison inputs
    input  wire logic [`HPC_CNT_W-1:0]    count,
    input  wire logic [`HPC_EV_W-1:0]     eventVal,
    input  wire logic                     subEn,
    input  wire logic [1:0]               resSel,
    // Match result
    output logic                          hit,
    output logic [`HPC_PHASE_BITS-1:0]    phase
);

    logic                       hit_d;
    logic                       hit_q;
    logic [`HPC_PHASE_BITS-1:0] phase_d;
    logic [`HPC_PHASE_BITS-1:0] phase_q;

    // Compare coarse part, mask phase to the selected resolution
    always_comb begin
        hit_d   = (count == eventVal[`HPC_EV_W-1:`HPC_PHASE_BITS]);
        phase_d = eventVal[`HPC_PHASE_BITS-1:0];
        if (!subEn) begin
            phase_d = 4'h0;
        end else if (resSel == 2'b01) begin
            phase_d = {phase_d[3:1], 1'b0};
        end else if (resSel == 2'b10) begin
            phase_d = {phase_d[3:2], 2'b00};
        end else if (resSel == 2'b11) begin
            phase_d = {phase_d[3], 3'b000};
        end
    end

    // Register the match
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hit_q   <= 1'b0;
            phase_q <= 4'h0;
        end else begin
            hit_q   <= hit_d;
            phase_q <= phase_d;
        end
    end

    assign hit   = hit_q;
    assign phase = phase_q;

endmodule : hpc_edge_cmp

//--- rtl/hpc_channel.sv
`timescale 1ns/1ps
`include "hpc_regs.svh"

module hpc_channel (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    // Register port
    input  wire logic [3:0]               regAddr,
    input  wire logic [31:0]              regWdata,
    input  wire logic                     regWr,
    input  wire logic                     regRd,
    output logic [31:0]                   regRdata,
    // Compensator values
    input  wire logic [`HPC_EV_W-1:0]     compDuty,
    input  wire logic [`HPC_CNT_W-1:0]    compPeriod,
    // Sync
    input  wire logic                     syncIn,
    output logic                          syncOut,
    // Error converter trigger and slave start
    output logic                          sampleTrig,
    output logic                          phaseTrig,
    // Switch outputs with sub-clock phase
    output logic                          outA,
    output logic                          outB,
    output logic [`HPC_PHASE_BITS-1:0]    phaseA,
    output logic [`HPC_PHASE_BITS-1:0]    phaseB
);

    localparam int CW = `HPC_CNT_W;
    localparam int EW = `HPC_EV_W;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [11:0]   ctrl_q,    ctrl_d;
    logic [CW-1:0] perShd_q,  perShd_d;
    logic [CW-1:0] ev1_q,     ev1_d;
    logic [EW-1:0] ev2_q,     ev2_d;
    logic [EW-1:0] ev3_q,     ev3_d;
    logic [EW-1:0] ev4_q,     ev4_d;
    logic [11:0]   sample_q,  sample_d;
    logic [CW-1:0] phCnt_q,   phCnt_d;
    logic [CW-1:0] syncTh_q,  syncTh_d;
    logic [15:0]   adjA_q,    adjA_d;
    logic [15:0]   adjB_q,    adjB_d;
    logic [31:0]   rdata_q,   rdata_d;
    // Time base state, declared here because status reads show it
    logic [CW-1:0] cnt_q,     cnt_d;
    logic [CW-1:0] perAct_q,  perAct_d;

    // Next register values; status reads show live counter and active period
    always_comb begin
        ctrl_d   = ctrl_q;
        perShd_d = perShd_q;
        ev1_d    = ev1_q;
        ev2_d    = ev2_q;
        ev3_d    = ev3_q;
        ev4_d    = ev4_q;
        sample_d = sample_q;
        phCnt_d  = phCnt_q;
        syncTh_d = syncTh_q;
        adjA_d   = adjA_q;
        adjB_d   = adjB_q;
        rdata_d  = 32'h0000_0000;
        if (regWr) begin
            if (regAddr == `HPC_ADDR_CTRL) begin
                ctrl_d = regWdata[11:0];
            end else if (regAddr == `HPC_ADDR_PERIOD) begin
                perShd_d = regWdata[CW-1:0];
            end else if (regAddr == `HPC_ADDR_EV1) begin
                ev1_d = regWdata[CW-1:0];
            end else if (regAddr == `HPC_ADDR_EV2) begin
                ev2_d = regWdata[EW-1:0];
            end else if (regAddr == `HPC_ADDR_EV3) begin
                ev3_d = regWdata[EW-1:0];
            end else if (regAddr == `HPC_ADDR_EV4) begin
                ev4_d = regWdata[EW-1:0];
            end else if (regAddr == `HPC_ADDR_SAMPLE) begin
                sample_d = regWdata[11:0];
            end else if (regAddr == `HPC_ADDR_PHASE) begin
                phCnt_d = regWdata[CW-1:0];
            end else if (regAddr == `HPC_ADDR_SYNCTH) begin
                syncTh_d = regWdata[CW-1:0];
            end else if (regAddr == `HPC_ADDR_ADJA) begin
                adjA_d = regWdata[15:0];
            end else if (regAddr == `HPC_ADDR_ADJB) begin
                adjB_d = regWdata[15:0];
            end
        end
        if (regRd) begin
            if (regAddr == `HPC_ADDR_CTRL) begin
                rdata_d = {20'h0_0000, ctrl_q};
            end else if (regAddr == `HPC_ADDR_PERIOD) begin
                rdata_d = {18'h0_0000, perShd_q};
            end else if (regAddr == `HPC_ADDR_EV1) begin
                rdata_d = {18'h0_0000, ev1_q};
            end else if (regAddr == `HPC_ADDR_EV2) begin
                rdata_d = {14'h0000, ev2_q};
            end else if (regAddr == `HPC_ADDR_EV3) begin
                rdata_d = {14'h0000, ev3_q};
            end else if (regAddr == `HPC_ADDR_EV4) begin
                rdata_d = {14'h0000, ev4_q};
            end else if (regAddr == `HPC_ADDR_SAMPLE) begin
                rdata_d = {20'h0_0000, sample_q};
            end else if (regAddr == `HPC_ADDR_PHASE) begin
                rdata_d = {18'h0_0000, phCnt_q};
            end else if (regAddr == `HPC_ADDR_SYNCTH) begin
                rdata_d = {18'h0_0000, syncTh_q};
            end else if (regAddr == `HPC_ADDR_ADJA) begin
                rdata_d = {16'h0000, adjA_q};
            end else if (regAddr == `HPC_ADDR_ADJB) begin
                rdata_d = {16'h0000, adjB_q};
            end else if (regAddr == `HPC_ADDR_STATUS) begin
                rdata_d = {4'h0, perAct_q, cnt_q};
            end
        end
    end

    // Register state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q   <= `HPC_CTRL_RST;
            perShd_q <= `HPC_PERIOD_RST;
            ev1_q    <= 14'h0000;
            ev2_q    <= 18'h0_0000;
            ev3_q    <= 18'h0_0000;
            ev4_q    <= 18'h0_0000;
            sample_q <= 12'h000;
            phCnt_q  <= 14'h0000;
            syncTh_q <= 14'h0000;
            adjA_q   <= 16'h0000;
            adjB_q   <= 16'h0000;
            rdata_q  <= 32'h0000_0000;
        end else begin
            ctrl_q   <= ctrl_d;
            perShd_q <= perShd_d;
            ev1_q    <= ev1_d;
            ev2_q    <= ev2_d;
            ev3_q    <= ev3_d;
            ev4_q    <= ev4_d;
            sample_q <= sample_d;
            phCnt_q  <= phCnt_d;
            syncTh_q <= syncTh_d;
            adjA_q   <= adjA_d;
            adjB_q   <= adjB_d;
            rdata_q  <= rdata_d;
        end
    end

    assign regRdata = rdata_q;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    hpc_pkg::hpc_mode_t mode;
    logic               chEn;
    logic               loopEn;
    logic               subEn;
    logic [1:0]         resSel;
    logic [1:0]         ovsSel;
    logic               slaveEn;

    assign mode    = hpc_pkg::hpc_mode_t'(ctrl_q[`HPC_CTRL_MODE_HI:`HPC_CTRL_MODE_LO]);
    assign chEn    = ctrl_q[`HPC_CTRL_EN];
    assign loopEn  = ctrl_q[`HPC_CTRL_LOOP];
    assign subEn   = ~ctrl_q[`HPC_CTRL_SUBDIS];
    assign resSel  = ctrl_q[`HPC_CTRL_RES_HI:`HPC_CTRL_RES_LO];
    assign ovsSel  = ctrl_q[`HPC_CTRL_OVS_HI:`HPC_CTRL_OVS_LO];
    assign slaveEn = ctrl_q[`HPC_CTRL_SLAVE];

    // ------------------------------------------------------------------
    // Effective event positions per mode
    // ------------------------------------------------------------------
    logic [EW-1:0] adjAx, adjBx, e2, e3, e4, dlt32, dltP4;
    logic [CW-1:0] perTgt;
    logic [CW-1:0] phOff;

    // Sign-extended adjusts in 18-bit event units (coarse << 4 | phase)
    assign adjAx = {{2{adjA_q[15]}}, adjA_q};
    assign adjBx = {{2{adjB_q[15]}}, adjB_q};
    assign dlt32 = ev3_q - ev2_q;
    assign dltP4 = {perShd_q, 4'h0} - ev4_q;

    // Position selection per operating mode
    always_comb begin
        e2     = ev2_q;
        e3     = ev3_q;
        e4     = ev4_q;
        perTgt = perShd_q;
        phOff  = 14'h0000;
        case (mode)
            hpc_pkg::HPC_MODE_NORMAL: begin
                if (loopEn) begin
                    e2 = compDuty;
                    e3 = compDuty + dlt32;
                end
                // front dead time from events 4 and 1
                e4 = ev4_q + adjBx;
            end
            hpc_pkg::HPC_MODE_PHASE: begin
                if (loopEn) begin
                    phOff = compDuty[EW-1:4];
                end
                e4 = ev4_q + adjBx;
            end
            hpc_pkg::HPC_MODE_RESONANT: begin
                if (loopEn) begin
                    perTgt = compPeriod;
                    e2     = compDuty;
                    e3     = compDuty + dlt32;
                end
                // event 4 from period gap; adjust A trims period
                perTgt = perTgt + adjA_q[15:4];
                e4     = {perTgt, 4'h0} - dltP4;
            end
            default: begin
                // duty sets both widths, B may wrap
                if (loopEn) begin
                    e2 = {ev1_q, 4'h0} + compDuty;
                    e4 = ev3_q + compDuty;
                end else begin
                    e4 = ev4_q;
                end
                e4 = e4 + adjBx;
            end
        endcase
        if (mode != hpc_pkg::HPC_MODE_RESONANT) begin
            e2 = e2 + adjAx;
        end
    end

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    logic          eop;
    logic [1:0]    qdiv_q,   qdiv_d;

    assign eop = (cnt_q >= perAct_q);

    // Counter, shadow transfer and quarter-rate divider
    always_comb begin
        cnt_d    = cnt_q;
        perAct_d = perAct_q;
        qdiv_d   = qdiv_q + 2'h1;
        if (!chEn) begin
            cnt_d  = 14'h0000;
            qdiv_d = 2'h0;
        // sync resets ramp (slave loads phase offset)
        end else if (syncIn) begin
            cnt_d  = slaveEn ? phOff : 14'h0000;
            qdiv_d = 2'h0;
        end else if (eop) begin
            cnt_d    = 14'h0000;
            // shadow to active at end of period
            perAct_d = perTgt;
        end else begin
            cnt_d = cnt_q + 14'h0001;
        end
    end

    // Time base state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q    <= 14'h0000;
            perAct_q <= `HPC_PERIOD_RST;
            qdiv_q   <= 2'h0;
        end else begin
            cnt_q    <= cnt_d;
            perAct_q <= perAct_d;
            qdiv_q   <= qdiv_d;
        end
    end

    // ------------------------------------------------------------------
    // Edge comparators
    // ------------------------------------------------------------------
    logic hit1, hit2, hit3, hit4;
    logic [3:0] ph2, ph3, ph4;

    // event 1 compared at coarse resolution only
    assign hit1 = chEn && (cnt_q == ev1_q);

    // events 2..4 split phase and coarse count
    hpc_edge_cmp uCmp2 (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .count    (cnt_q),
        .eventVal (e2),
        .subEn    (subEn),
        .resSel   (resSel),
        .hit      (hit2),
        .phase    (ph2)
    );
    hpc_edge_cmp uCmp3 (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .count    (cnt_q),
        .eventVal (e3),
        .subEn    (subEn),
        .resSel   (resSel),
        .hit      (hit3),
        .phase    (ph3)
    );
    hpc_edge_cmp uCmp4 (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .count    (cnt_q),
        .eventVal (e4),
        .subEn    (subEn),
        .resSel   (resSel),
        .hit      (hit4),
        .phase    (ph4)
    );

    // ------------------------------------------------------------------
    // Output and trigger generation
    // ------------------------------------------------------------------
    logic       rawA_q, rawA_d, rawB_q, rawB_d, hit1_q;
    logic       outA_q, outA_d, outB_q, outB_d;
    logic [3:0] phA_q, phA_d, phB_q, phB_d;
    logic       sync_q, sync_d, samp_q, samp_d, phtr_q, phtr_d;
    logic [CW-1:0] sampPos;
    logic [CW-1:0] subPer;
    logic [CW-1:0] cntSub;
    logic [CW-1:0] posSub;

    // Sample position is in quarter-rate units; oversampling divides period
    assign sampPos = {sample_q, 2'b00};
    assign subPer  = perAct_q >> ovsSel;
    // Compare in quarter-rate units so each full four-count window meets one divider strobe
    assign cntSub  = cnt_q % (subPer + 14'h0001);
    assign posSub  = sampPos % (subPer + 14'h0001);

    // Edge set/reset, polarity and one-cycle pulses
    always_comb begin
        rawA_d = rawA_q;
        rawB_d = rawB_q;
        phA_d  = phA_q;
        phB_d  = phB_q;
        // rise A, fall A, rise B, fall B; hit1 delayed to align
        if (hit1_q) begin
            rawA_d = 1'b1;
            phA_d  = 4'h0;
        end
        if (hit2) begin
            rawA_d = 1'b0;
            phA_d  = ph2;
        end
        if (hit3) begin
            rawB_d = 1'b1;
            phB_d  = ph3;
        end
        if (hit4) begin
            rawB_d = 1'b0;
            phB_d  = ph4;
        end
        if (!chEn) begin
            rawA_d = 1'b0;
            rawB_d = 1'b0;
        end
        outA_d = rawA_d ^ ctrl_q[`HPC_CTRL_POLA];
        outB_d = rawB_d ^ ctrl_q[`HPC_CTRL_POLB];
        sync_d = chEn && (cnt_q == syncTh_q);
        phtr_d = chEn && (cnt_q == phCnt_q);
        samp_d = 1'b0;
        if (chEn && qdiv_q == `HPC_QUARTER_DIV) begin
            if (ovsSel == 2'b00) begin
                samp_d = (cnt_q[CW-1:2] == sample_q);
            end else begin
                samp_d = (cntSub[CW-1:2] == posSub[CW-1:2]);
            end
        end
    end

    // Output state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rawA_q <= 1'b0;
            rawB_q <= 1'b0;
            hit1_q <= 1'b0;
            outA_q <= 1'b0;
            outB_q <= 1'b0;
            phA_q  <= 4'h0;
            phB_q  <= 4'h0;
            sync_q <= 1'b0;
            samp_q <= 1'b0;
            phtr_q <= 1'b0;
        end else begin
            rawA_q <= rawA_d;
            rawB_q <= rawB_d;
            hit1_q <= hit1;
            outA_q <= outA_d;
            outB_q <= outB_d;
            phA_q  <= phA_d;
            phB_q  <= phB_d;
            sync_q <= sync_d;
            samp_q <= samp_d;
            phtr_q <= phtr_d;
        end
    end

    assign outA       = outA_q;
    assign outB       = outB_q;
    assign phaseA     = phA_q;
    assign phaseB     = phB_q;
    assign syncOut    = sync_q;
    assign sampleTrig = samp_q;
    assign phaseTrig  = phtr_q;

endmodule : hpc_channel

//--- sim/hpc_channel_asserts.sv
`timescale 1ns/1ps

// ----
// Port checker for one channel
// ----
module hpc_channel_asserts (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [3:0]  regAddr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    // Pulses and outputs
    input wire logic        syncOut,
    input wire logic        sampleTrig,
    input wire logic        phaseTrig,
    input wire logic        outA,
    input wire logic        outB
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Status read request, answered one cycle later
    sequence statusRead;
        regRd && regAddr == 4'hB;
    endsequence

    a_rdata_idle: assert property (!regRd |=> regRdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (regRd && regAddr > 4'hB |=> regRdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (!$past(rst_n) |-> !(outA || outB || syncOut || phaseTrig))
        else $error("outputs active right after reset");
    a_status_top: assert property (statusRead |=> regRdata[31:28] == 4'h0)
        else $error("status upper bits not zero");
    a_count_bound: assert property (statusRead |=> regRdata[13:0] <= regRdata[27:14])
        else $error("counter above active period");
    a_sync_pulse: assert property (syncOut |=> !syncOut)
        else $error("sync out longer than one cycle");
    a_phase_pulse: assert property (phaseTrig |=> !phaseTrig)
        else $error("phase trigger longer than one cycle");
    a_sample_pulse: assert property (sampleTrig |=> !sampleTrig)
        else $error("sample trigger longer than one cycle");
endmodule : hpc_channel_asserts

bind hpc_channel hpc_channel_asserts u_chk (.ref_clk, .rst_n, .regAddr, .regRd, .regRdata,
    .syncOut, .sampleTrig, .phaseTrig, .outA, .outB);

//--- sim/hpc_comp_model.sv
`timescale 1ns/1ps
`include "hpc_regs.svh"

// Compensator and sync source in front of the channel
module hpc_comp_model (
    // Clock
    input  wire logic                        ref_clk,
    // Requests from the bench
    input  wire logic signed [`HPC_EV_W-1:0] dutyReq,
    input  wire logic [`HPC_CNT_W-1:0]       periodReq,
    input  wire logic                        syncReq,
    // Values toward the channel
    output logic [`HPC_EV_W-1:0]             compDuty,
    output logic [`HPC_CNT_W-1:0]            compPeriod,
    output logic                             syncIn
);
    // Registered like a real accelerator result, so values never move mid-cycle
    // negative width clamped
    always_ff @(posedge ref_clk) begin
        compDuty   <= (dutyReq < 0) ? '0 : dutyReq;
        compPeriod <= periodReq;
        syncIn     <= syncReq;
    end
endmodule : hpc_comp_model

//--- sim/hpc_channel_tb_top.sv
`timescale 1ns/1ps
`include "hpc_regs.svh"

module hpc_channel_tb_top;
    logic               ref_clk = 0, rst_n = 0, regWr = 0, regRd = 0, syncReq = 0;
    logic [3:0]         regAddr = 4'h0;
    logic [31:0]        regWdata = 32'h0000_0000, regRdata, rv;
    logic signed [17:0] dutyReq = 18'sh0_0000;
    logic [13:0]        periodReq = 14'h0000, compPeriod;
    logic [17:0]        compDuty;
    logic               syncIn, syncOut, sampleTrig, phaseTrig, outA, outB;
    logic [3:0]         phaseA, phaseB;
    int                 error_cnt = 0, comparisons = 0, nA, nB, nS, nP;

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

    // Free-running 200 MHz clock
    initial forever #2.5 ref_clk = ~ref_clk;

    hpc_channel dut (.ref_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .compDuty, .compPeriod, .syncIn, .syncOut, .sampleTrig, .phaseTrig,
        .outA, .outB, .phaseA, .phaseB);
    hpc_comp_model u_comp (.ref_clk, .dutyReq, .periodReq, .syncReq, .compDuty,
        .compPeriod, .syncIn);

    // ----
    // Bus tasks; a gap cycle keeps strobes from being assigned twice in a step
    // ----
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
        rv = regRdata;
    endtask : rd

    // Counts high cycles of each output over a window
    task automatic cnt(input int n);
        {nA, nB, nS, nP} = '0;
        repeat (n) begin
            @(posedge ref_clk);
            nA += outA;
            nB += outB;
            nS += sampleTrig + syncOut * 256;
            nP += phaseTrig;
        end
    endtask : cnt

    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #100us;
        error_cnt++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(`HPC_ADDR_PERIOD); `CHK("period", 32'h0000_00FF, rv)
        rd(4'hC); `CHK("unmapped", 32'h0000_0000, rv)
        for (int m = 0; m < 4; m++) begin
            wr(`HPC_ADDR_CTRL, (m << 1) | (m << 6));
            rd(`HPC_ADDR_CTRL); `CHK("ctrl", (m << 1) | (m << 6), rv)
        end
        $display("reset test done");
        wr(`HPC_ADDR_CTRL, 32'h0000_0001);
        wr(`HPC_ADDR_PERIOD, 32'h0000_0014);
        rd(`HPC_ADDR_STATUS); `CHK("old period", 14'h00FF, rv[27:14])
        repeat (300) @(posedge ref_clk);
        rd(`HPC_ADDR_STATUS); `CHK("new period", 14'h0014, rv[27:14])
        $display("shadow test done");
        wr(`HPC_ADDR_EV1, 32'h2);
        wr(`HPC_ADDR_EV2, 32'hA0);
        wr(`HPC_ADDR_EV3, 32'hC0);
        wr(`HPC_ADDR_EV4, 32'h120);
        wr(`HPC_ADDR_SYNCTH, 32'h5);
        wr(`HPC_ADDR_PHASE, 32'h7);
        repeat (50) @(posedge ref_clk);
        cnt(84); `CHK("A width", 32, nA)
        `CHK("B width", 24, nB)
        `CHK("sync", 4, nS / 256)
        `CHK("phase", 4, nP)
        wr(`HPC_ADDR_CTRL, 32'h31);
        repeat (50) @(posedge ref_clk);
        cnt(84); `CHK("A inv", 52, nA)
        `CHK("B inv", 60, nB)
        dutyReq <= 18'sh0_00E0;
        wr(`HPC_ADDR_CTRL, 32'h09);
        repeat (50) @(posedge ref_clk);
        cnt(84); `CHK("A loop", 48, nA)
        `CHK("B loop", 8, nB)
        dutyReq <= 18'sh0_0050;
        wr(`HPC_ADDR_CTRL, 32'h0F);
        repeat (50) @(posedge ref_clk);
        cnt(84); `CHK("A multi", 20, nA)
        `CHK("B multi", 20, nB)
        $display("edge test done");
        wr(`HPC_ADDR_PERIOD, 32'h3F);
        for (int v = 0; v < 4; v++) begin
            wr(`HPC_ADDR_CTRL, 1 | (v << 9));
            repeat (70) @(posedge ref_clk);
            cnt(128); `CHK("samples", 2 << v, nS % 256)
        end
        for (int i = 0; i < 40 && rv[13:0] < 30; i++) rd(`HPC_ADDR_STATUS);
        syncReq <= 1'b1;
        @(posedge ref_clk);
        syncReq <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(`HPC_ADDR_STATUS); `CHK("sync reset", 1'b1, rv[13:0] < 8)
        $display("sample test done");
        // Event 2 on event 1 keeps A low; B edges share phase 7, so phases stay put
        wr(`HPC_ADDR_EV2, 32'h27);
        wr(`HPC_ADDR_EV3, 32'hC7);
        wr(`HPC_ADDR_EV4, 32'h127);
        for (int r = 0; r < 5; r++) begin
            wr(`HPC_ADDR_CTRL, 1 | (r << 6));
            repeat (70) @(posedge ref_clk);
            `CHK("phase A", 4'h7 & (4'hF << r), phaseA)
            `CHK("phase B", 4'h7 & (4'hF << r), phaseB)
        end
        $display("phase test done");
        periodReq <= 14'h001E;
        wr(`HPC_ADDR_CTRL, 32'h0D);
        repeat (80) @(posedge ref_clk);
        cnt(93); `CHK("res period", 3, nS / 256)
        $display("resonant test done");
        close_out();
    end
endmodule : hpc_channel_tb_top
